// >>> core/wake_consts.svh
// Register offsets, field positions, reset values and frame offsets of the wake filters
`ifndef WAKE_CONSTS_SVH
`define WAKE_CONSTS_SVH
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_IMASK 12'h008
`define A_MACL 12'h00c
`define A_MACH 12'h010
`define A_WLEN 12'h014
`define R_IP4 8'h02
`define R_IP6 8'h03
`define R_FLEN 8'h04
`define R_FMASK 6'h02
`define R_FVAL 2'h1
`define R_WPM 5'h10
`define B_IP4 0
`define B_IP6 1
`define B_FLEX 2
`define B_PME 6
`define B_STORE 6
`define CTRL_RST 7'h00
`define STAT_RST 7'h00
`define IMASK_RST 7'h00
`define MAC_RST 48'h000000000000
`define WORD_RST 32'h00000000
`define FLEN_RST 8'h00
`define ET_VLAN 16'h8100
`define ET_IPV4 16'h0800
`define ET_IPV6 16'h0800
`define SNAP_MAX 16'h05dc
`define SNAP_HDR 48'haaaa03000000
`define MAC_END 8'h05
`define TYPE_END 8'h0d
`define VLAN_LEN 8'h04
`define SNAP_LEN 8'h08
`define SNAP_CHK 8'h06
`define IP4_VER 8'h45
`define IP6_VER 4'h6
`define IP4_DST_END 8'h13
`define IP6_HI_END 8'h1f
`define IP6_LO_END 8'h27
`define FLEX_BYTES 8'h80
`endif

// >>> core/wake_pkg.sv
// Types shared by the wake filter design
package wake_pkg;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} ahb_req_t;
	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic good;
		logic [7:0] data;
	} rx_beat_t;
endpackage

// >>> core/packet_store.sv
// Capture buffer for the first bytes of a received frame
`timescale 1ns/1ps
`include "wake_consts.svh"
module packet_store (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Byte write
	input wire logic we_i,
	input wire logic [6:0] idx_i,
	input wire logic [7:0] data_i,
	// Word read
	input wire logic [4:0] raddr_i,
	output logic [31:0] rdata_o,
	output logic [7:0] len_o
);
	logic [31:0] mem_q [32];
	logic [7:0] len_q;

	// Bytes packed little-endian into words
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < 32; i++) begin
				mem_q[i] <= `WORD_RST;
			end
		end else if (ce_i && we_i) begin
			mem_q[idx_i[6:2]][{idx_i[1:0], 3'b000} +: 8] <= data_i;
		end
	end

	// Captured length follows the last byte written
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			len_q <= 8'h00;
		end else if (ce_i && we_i) begin
			len_q <= {1'b0, idx_i} + 8'h01;
		end
	end

	assign rdata_o = mem_q[raddr_i];
	assign len_o = len_q;
endmodule

// >>> core/flex_filter.sv
// One flexible byte-pattern filter with its mask, value and length tables
`timescale 1ns/1ps
`include "wake_consts.svh"
module flex_filter import wake_pkg::*; (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Frame bytes
	input wire rx_beat_t rx_i,
	input wire logic [7:0] idx_i,
	// Table access
	input wire logic wr_val_i,
	input wire logic wr_mask_i,
	input wire logic wr_len_i,
	input wire logic [4:0] waddr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [4:0] raddr_i,
	output logic [31:0] val_rd_o,
	output logic [31:0] mask_rd_o,
	output logic [7:0] len_o,
	// Result
	output logic hit_o
);
	logic [31:0] val_q [32];
	logic [127:0] mask_q;
	logic [7:0] len_q;
	logic fail_q, pass_q, fail_n, pass_n, bad, inrange;
	logic [7:0] vbyte;

	// Tables written by software
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < 32; i++) begin
				val_q[i] <= `WORD_RST;
			end
			mask_q <= '0;
			len_q <= `FLEN_RST;
		end else if (ce_i) begin
			if (wr_val_i) begin
				val_q[waddr_i] <= wdata_i;
			end
			if (wr_mask_i) begin
				mask_q[{waddr_i[1:0], 5'b00000} +: 32] <= wdata_i;
			end
			if (wr_len_i) begin
				len_q <= wdata_i[7:0];
			end
		end
	end

	// Positions are absolute from frame start, no header skipping
	assign vbyte = val_q[idx_i[6:2]][{idx_i[1:0], 3'b000} +: 8]; // R15
	assign inrange = (idx_i < len_q) && (idx_i < `FLEX_BYTES); // R09 R14
	assign bad = inrange && mask_q[idx_i[6:0]] && (rx_i.data != vbyte); // R12
	assign fail_n = (rx_i.first ? 1'b0 : fail_q) | bad;
	assign pass_n = (rx_i.first ? 1'b0 : pass_q) | ((len_q != 8'h00) && (idx_i == len_q - 8'h01) && !fail_n); // R13

	// Per-frame verdict, restarted on the first byte
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fail_q <= 1'b0;
			pass_q <= 1'b0;
		end else if (ce_i && rx_i.valid) begin
			fail_q <= fail_n;
			pass_q <= pass_n;
		end
	end

	assign hit_o = rx_i.valid ? pass_n : pass_q;
	assign val_rd_o = val_q[raddr_i];
	assign mask_rd_o = mask_q[{raddr_i[1:0], 5'b00000} +: 32];
	assign len_o = len_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	chk_flex_fail: assert property (ce_i && rx_i.valid && bad |=> fail_q) else $error("masked mismatch not failed"); // R12
	chk_flex_pass: assert property ($rose(pass_q) |-> !$past(fail_q) || $past(rx_i.first)) else $error("pass after fail"); // R13
	chk_flex_beyond: assert property (ce_i && rx_i.valid && !rx_i.first && !fail_q && idx_i >= len_q |=> !fail_q)
		else $error("mask beyond length used"); // R14
endmodule

// >>> core/wake_packet_filters.sv
// Wake packet filters: directed IPv4/IPv6, four flexible filters, capture, AHB-Lite registers
//
// Operation
// [R01] Directed IPv4 match counts only while the IPv4 enable bit is set.
// [R02] Four IPv4 wake addresses are held in a software table.
// [R03] IPv4 match needs own MAC destination, type 0800h, table address hit.
// [R04] Destination IP at 30 plus tag and SNAP compared with all four entries.
// [R05] VLAN tag 8100h and SNAP length up to 1500 shift later offsets.
// [R06] IPv6 match counts only while IPv6 enable set; one address held.
// [R07] IPv6 match needs own MAC, the protocol type, and the programmed address.
// [R08] IPv6 filter also handles VLAN-tagged Ethernet II and SNAP frames.
// [R09] Four independent flexible filters over the first 128 bytes.
// [R10] Software programs mask, value and length tables of each flexible filter.
// [R11] Software enables flexible filters and the power event enable bit.
// [R12] A masked byte differing from its value fails the flexible filter.
// [R13] Reaching the minimum length without failure passes and raises a wakeup.
// [R14] Mask bits beyond the programmed length are ignored.
// [R15] Flexible positions are absolute; no VLAN or SNAP skipping.
// [R16] On a wakeup the first 128 frame bytes are kept for software.
// [R17] All filters run together; one wakeup per frame if any matches.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "wake_consts.svh"
module wake_packet_filters import wake_pkg::*; (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// AHB-Lite slave
	input wire ahb_req_t ahb_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Receive byte stream
	input wire rx_beat_t rx_i,
	// Events
	output logic wake_o,
	output logic irq_o
);
	logic take, wr_q, wr, beat, fend, any, lock, enc_ok, store_we;
	logic [11:0] wa_q, ra;
	logic [31:0] hrdata_q, rd_d;
	logic [6:0] ctrl_q, stat_q, imask_q, w1c;
	logic [5:0] hit, ev;
	logic [47:0] mac_q;
	logic [31:0] ip4_q [4];
	logic [31:0] ip6_q [4];
	logic [7:0] cnt_q, idx, tp1, base;
	logic [55:0] sh_q;
	logic [63:0] win;
	logic [15:0] word, et_q;
	logic mac_ok_q, vlan_q, snap_q, snap_ok_q, ver4_q, ver6_q, ip4_hit_q, ip6_hi_q, ip6_lo_q;
	logic [3:0] ip4_eq, flex_hit;
	logic [31:0] fval_rd [4];
	logic [31:0] fmask_rd [4];
	logic [7:0] flen_rd [4];
	logic [31:0] wpm_rd;
	logic [7:0] wlen;
	logic wake_q;

	// Address phase taken only while enabled; data phase stretched when frozen
	assign take = ce_i && ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
	assign hreadyout_o = ce_i;
	assign hresp_o = 1'b0;
	assign wr = ce_i && wr_q;
	assign ra = ahb_i.haddr[11:0];

	// Write address phase kept for the data phase
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_q <= 1'b0;
			wa_q <= 12'h000;
		end else if (ce_i) begin
			wr_q <= take && ahb_i.hwrite;
			if (take) begin
				wa_q <= ra;
			end
		end
	end

	// Control, mask and address tables
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_q <= `CTRL_RST;
			imask_q <= `IMASK_RST;
			mac_q <= `MAC_RST;
			for (int i = 0; i < 4; i++) begin
				ip4_q[i] <= `WORD_RST;
				ip6_q[i] <= `WORD_RST;
			end
		end else if (wr) begin
			if (wa_q == `A_CTRL) begin
				ctrl_q <= hwdata_i[6:0];
			end
			if (wa_q == `A_IMASK) begin
				imask_q <= hwdata_i[6:0];
			end
			if (wa_q == `A_MACL) begin
				mac_q[47:16] <= hwdata_i;
			end
			if (wa_q == `A_MACH) begin
				mac_q[15:0] <= hwdata_i[15:0];
			end
			if (wa_q[11:4] == `R_IP4) begin
				ip4_q[wa_q[3:2]] <= hwdata_i; // R02
			end
			if (wa_q[11:4] == `R_IP6) begin
				ip6_q[wa_q[3:2]] <= hwdata_i; // R06
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 32'h00000000;
		if (ra[11:10] == `R_FVAL) begin
			rd_d = fval_rd[ra[8:7]];
		end else if (ra[11:7] == `R_WPM) begin
			rd_d = wpm_rd;
		end else if (ra[11:6] == `R_FMASK) begin
			rd_d = fmask_rd[ra[5:4]];
		end else if (ra[11:4] == `R_IP4) begin
			rd_d = ip4_q[ra[3:2]];
		end else if (ra[11:4] == `R_IP6) begin
			rd_d = ip6_q[ra[3:2]];
		end else if (ra[11:4] == `R_FLEN) begin
			rd_d = {24'h000000, flen_rd[ra[3:2]]};
		end else if (ra == `A_CTRL) begin
			rd_d = {25'h0000000, ctrl_q};
		end else if (ra == `A_STAT) begin
			rd_d = {25'h0000000, stat_q};
		end else if (ra == `A_IMASK) begin
			rd_d = {25'h0000000, imask_q};
		end else if (ra == `A_MACL) begin
			rd_d = mac_q[47:16];
		end else if (ra == `A_MACH) begin
			rd_d = {16'h0000, mac_q[15:0]};
		end else if (ra == `A_WLEN) begin
			rd_d = {24'h000000, wlen};
		end
	end

	// Read data registered at the address phase, stands through the data phase
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hrdata_q <= 32'h00000000;
		end else if (take && !ahb_i.hwrite) begin
			hrdata_q <= rd_d;
		end
	end
	assign hrdata_o = hrdata_q;

	// Byte position within the frame, saturating
	assign beat = ce_i && rx_i.valid;
	assign idx = rx_i.first ? 8'h00 : cnt_q;
	assign win = {sh_q, rx_i.data};
	assign word = win[15:0];
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q <= 8'h00;
			sh_q <= '0;
		end else if (beat) begin
			cnt_q <= (idx == 8'hff) ? idx : idx + 8'h01;
			sh_q <= win[55:0];
		end
	end

	// Type field moves with a VLAN tag; IP header moves with a SNAP header
	assign tp1 = `TYPE_END + (vlan_q ? `VLAN_LEN : 8'h00); // R05 R08
	assign base = tp1 + 8'h01 + (snap_q ? `SNAP_LEN : 8'h00); // R05 R08
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ip4_eq[i] = (win[31:0] == ip4_q[i]); // R04
		end
	end

	// Header parse; each check sits at the last byte it needs, shifted by tag and SNAP
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{mac_ok_q, vlan_q, snap_q, snap_ok_q, ver4_q, ver6_q, ip4_hit_q, ip6_hi_q, ip6_lo_q} <= 9'h000;
			et_q <= 16'h0000;
		end else if (beat && rx_i.first) begin
			{mac_ok_q, vlan_q, snap_q, snap_ok_q, ver4_q, ver6_q, ip4_hit_q, ip6_hi_q, ip6_lo_q} <= 9'h000;
			et_q <= 16'h0000;
		end else if (beat) begin
			if (idx == `MAC_END) begin
				mac_ok_q <= (win[47:0] == mac_q); // R03 R07
			end
			if (idx == `TYPE_END && word == `ET_VLAN) begin
				vlan_q <= 1'b1; // R05 R08
			end else if (idx == tp1) begin
				if (word <= `SNAP_MAX) begin
					snap_q <= 1'b1; // R05 R08
				end else begin
					et_q <= word;
				end
			end
			if (snap_q && idx == tp1 + `SNAP_CHK) begin
				snap_ok_q <= (win[47:0] == `SNAP_HDR);
			end
			if (snap_q && idx == tp1 + `SNAP_LEN) begin
				et_q <= word;
			end
			if (idx == base) begin
				ver4_q <= (rx_i.data == `IP4_VER);
				ver6_q <= (rx_i.data[7:4] == `IP6_VER);
			end
			if (idx == base + `IP4_DST_END) begin
				ip4_hit_q <= |ip4_eq; // R04
			end
			if (idx == base + `IP6_HI_END) begin
				ip6_hi_q <= (win == {ip6_q[0], ip6_q[1]}); // R07
			end
			if (idx == base + `IP6_LO_END) begin
				ip6_lo_q <= (win == {ip6_q[2], ip6_q[3]}); // R07
			end
		end
	end

	// Four flexible filters watching the same byte stream
	generate
		for (genvar f = 0; f < 4; f++) begin : g_flex
			flex_filter u_flex (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.ce_i(ce_i),
				.rx_i(rx_i),
				.idx_i(idx),
				.wr_val_i(wr && wa_q[11:10] == `R_FVAL && wa_q[8:7] == f[1:0]),
				.wr_mask_i(wr && wa_q[11:6] == `R_FMASK && wa_q[5:4] == f[1:0]),
				.wr_len_i(wr && wa_q[11:4] == `R_FLEN && wa_q[3:2] == f[1:0]),
				.waddr_i(wa_q[6:2]),
				.wdata_i(hwdata_i),
				.raddr_i(ra[6:2]),
				.val_rd_o(fval_rd[f]),
				.mask_rd_o(fmask_rd[f]),
				.len_o(flen_rd[f]),
				.hit_o(flex_hit[f])
			); // R09
		end
	endgenerate

	// Verdicts combined at the end of a good frame
	assign enc_ok = mac_ok_q && (!snap_q || snap_ok_q);
	assign hit[`B_IP4] = ctrl_q[`B_IP4] && enc_ok && et_q == `ET_IPV4 && ver4_q && ip4_hit_q; // R01 R03
	assign hit[`B_IP6] = ctrl_q[`B_IP6] && enc_ok && et_q == `ET_IPV6 && ver6_q && ip6_hi_q && ip6_lo_q; // R06 R07
	assign hit[5:2] = ctrl_q[5:2] & flex_hit; // R13
	assign fend = beat && rx_i.last && rx_i.good && ctrl_q[`B_PME];
	assign ev = fend ? hit : 6'h00; // R17
	assign any = |ev; // R17

	// Sticky status, write one to clear; a new event beats the clear
	assign w1c = (wr && wa_q == `A_STAT) ? hwdata_i[6:0] : 7'h00;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stat_q <= `STAT_RST;
			wake_q <= 1'b0;
		end else if (ce_i) begin
			stat_q <= (stat_q & ~w1c) | {any, ev};
			wake_q <= any; // R17
		end
	end
	assign wake_o = wake_q;
	assign irq_o = |(stat_q & imask_q);

	// Capture stays frozen while the stored flag is up
	assign lock = stat_q[`B_STORE];
	assign store_we = beat && !lock && (idx < `FLEX_BYTES); // R16
	packet_store u_store (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.we_i(store_we),
		.idx_i(idx[6:0]),
		.data_i(rx_i.data),
		.raddr_i(ra[6:2]),
		.rdata_o(wpm_rd),
		.len_o(wlen)
	);

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	chk_ipv4_enable: assert property ($rose(stat_q[0]) |-> $past(ctrl_q[0])) else $error("ipv4 event while disabled"); // R01
	chk_ipv6_enable: assert property ($rose(stat_q[1]) |-> $past(ctrl_q[1])) else $error("ipv6 event while disabled"); // R06
	chk_ipv4_fields: assert property (ev[0] |-> mac_ok_q && et_q == 16'h0800 && ip4_hit_q) else $error("ipv4 fields"); // R03
	chk_vlan_shift: assert property (beat && !rx_i.first && idx == 8'h0d && word == 16'h8100 |=> vlan_q && tp1 == 8'h11)
		else $error("vlan not shifted"); // R05
	chk_ipv6_addr: assert property (ev[1] |-> ip6_hi_q && ip6_lo_q && mac_ok_q) else $error("ipv6 address"); // R07
	chk_store_lock: assert property (lock && !w1c[6] |=> lock && !store_we) else $error("capture not frozen"); // R16
	chk_wake_event: assert property (any |=> wake_o && stat_q[6] ##1 !wake_o || $past(any)) else $error("wake pulse"); // R17
	chk_irq_raise: assert property (ce_i && |(ev & imask_q[5:0]) |=> irq_o) else $error("interrupt missed");
	cov_ipv4: cover property (ev[0]);
	cov_ipv6: cover property (ev[1]);
	cov_flex: cover property (|ev[5:2]);
	cov_vlan_snap: cover property (vlan_q && snap_q && snap_ok_q && any);
endmodule

// >>> tb/frame_source.sv
// Receive path model: plays one frame to the filters byte by byte
`timescale 1ns/1ps
module frame_source import wake_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Byte stream towards the filters
	output rx_beat_t rx_o
);
	logic [7:0] mem [0:127];

	// Idle line at time zero
	initial begin
		rx_o = '0;
	end

	// Frame always opens with first; gaps hold valid low with the data inverted
	task automatic send(input int len, input logic good, input logic slow);
		for (int i = 0; i < len; i++) begin
			@(posedge clk_i);
			rx_o <= '{1'b1, i == 0, i == len - 1, good, mem[i]};
			if (slow) begin
				@(posedge clk_i);
				rx_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~mem[i]};
			end
		end
		@(posedge clk_i);
		rx_o <= '{1'b0, 1'b0, 1'b0, 1'b0, ~mem[len - 1]};
	endtask
endmodule

// >>> tb/wake_packet_filters_tb_top.sv
// Self-checking bench for the wake packet filters
`timescale 1ns/1ps
`include "wake_consts.svh"
module wake_packet_filters_tb_top import wake_pkg::*; ;
	localparam logic [47:0] MAC = 48'h021122334455;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_q = 1'b1;
	ahb_req_t ahb_q = '0;
	ahb_req_t ahb_w;
	logic [31:0] hwdata_q = '0;
	logic [31:0] hrdata_o;
	logic [31:0] rd;
	logic [31:0] wakes = '0;
	logic hreadyout_o;
	logic hresp_o;
	logic wake_o;
	logic irq_o;
	rx_beat_t rx_w;
	logic [7:0] f [0:127];
	int miscompares = 0;
	int comparisons = 0;

	always #50 clk_i = ~clk_i;
	// Single slave, so its hreadyout is the bus hready
	assign ahb_w = '{ahb_q.hsel, ahb_q.haddr, ahb_q.htrans, ahb_q.hwrite, ahb_q.hsize, hreadyout_o};

	wake_packet_filters u_wake_packet_filters (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_q), .ahb_i(ahb_w),
		.hwdata_i(hwdata_q), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.rx_i(rx_w), .wake_o(wake_o), .irq_o(irq_o));
	frame_source u_frame_source (.clk_i(clk_i), .rx_o(rx_w));

	// Counts every wake pulse, so a doubled event shows up
	always @(posedge clk_i) begin
		if (wake_o === 1'b1) begin
			wakes <= wakes + 32'h1;
		end
	end

	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask

	// One AHB-Lite single word transfer; read data taken at the data phase edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		ahb_q <= '{1'b1, {20'h0, a}, 2'h2, wr, 3'h2, 1'b0};
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		ahb_q <= '0;
		hwdata_q <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check32(rd, exp);
		check1(hresp_o, 1'b0);
	endtask

	// Directed IP frame with optional VLAN tag and SNAP header
	task automatic build(input logic v, input logic s, input logic six, input logic [31:0] ip);
		int o;
		for (int i = 0; i < 128; i++) f[i] = i < 6 ? MAC[47 - 8 * i -: 8] : 8'h00;
		o = 12;
		if (v) begin
			f[12] = 8'h81;
			f[15] = 8'h05;
			o = 16;
		end
		if (s) begin
			f[o + 1] = 8'h40;
			f[o + 2] = 8'haa;
			f[o + 3] = 8'haa;
			f[o + 4] = 8'h03;
			o += 8;
		end
		f[o] = 8'h08;
		f[o + 2] = six ? 8'h60 : 8'h45;
		for (int k = 0; k < 4; k++) f[o + 18 + k] = ip[31 - 8 * k -: 8];
		for (int k = 0; k < 16; k++) f[o + 26 + k] = 8'h20 + k[7:0];
	endtask

	// Plays the frame, then checks the pulse count and the sticky status
	// Long enough that the last IPv6 byte of a tagged SNAP frame comes before the end
	task automatic run(input logic good, input logic slow, input logic [31:0] exp_w, input logic [31:0] exp_s);
		logic [31:0] base;
		base = wakes;
		for (int i = 0; i < 128; i++) u_frame_source.mem[i] = f[i];
		u_frame_source.send(72, good, slow);
		repeat (3) @(posedge clk_i);
		check32(wakes - base, exp_w);
		rdc(`A_STAT, exp_s);
	endtask

	task automatic clr();
		bus(1'b1, `A_STAT, 32'h7f);
	endtask

	task automatic finish_test();
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rdc(`A_CTRL, 32'h0);
		rdc(`A_IMASK, 32'h0);
		rdc(`A_WLEN, 32'h0);
		bus(1'b1, 12'h0f0, 32'h5a);
		rdc(12'h0f0, 32'h0);
		bus(1'b1, `A_MACL, MAC[47:16]);
		bus(1'b1, `A_MACH, {16'h0, MAC[15:0]});
		for (int k = 0; k < 4; k++) bus(1'b1, 12'h020 + 4 * k, 32'h0a000000 + k);
		rdc(12'h02c, 32'h0a000003);
		for (int w = 0; w < 4; w++) bus(1'b1, 12'h030 + 4 * w, 32'h20212223 + 32'h04040404 * w);
		bus(1'b1, `A_IMASK, 32'h1);
		bus(1'b1, `A_CTRL, 32'h43);
		// Every framing, every table entry, one IPv4 and one IPv6 frame with gaps between bytes
		for (int c = 0; c < 4; c++) begin
			build(c[0], c[1], 1'b0, 32'h0a000000 + c);
			run(1'b1, c == 1, 32'h1, 32'h41);
			clr();
			build(c[0], c[1], 1'b1, 32'h0);
			run(1'b1, c == 2, 32'h1, 32'h42);
			clr();
		end
		// Capture and interrupt on a plain hit
		build(1'b0, 1'b0, 1'b0, 32'h0a000000);
		run(1'b1, 1'b0, 32'h1, 32'h41);
		check1(irq_o, 1'b1);
		rdc(`A_WLEN, 32'h48);
		rdc(12'h800, 32'h33221102);
		rdc(12'h804, 32'h00005544);
		bus(1'b1, `A_IMASK, 32'h0);
		#1 check1(irq_o, 1'b0);
		clr();
		bus(1'b1, `A_IMASK, 32'h1);
		// Misses: bad address, foreign MAC, other type, bad CRC
		build(1'b0, 1'b0, 1'b0, 32'h0a000009);
		run(1'b1, 1'b0, 32'h0, 32'h0);
		build(1'b0, 1'b0, 1'b0, 32'h0a000001);
		f[0] = 8'h03;
		run(1'b1, 1'b0, 32'h0, 32'h0);
		f[0] = 8'h02;
		f[12] = 8'h86;
		run(1'b1, 1'b0, 32'h0, 32'h0);
		f[12] = 8'h08;
		run(1'b0, 1'b0, 32'h0, 32'h0);
		#1 check1(irq_o, 1'b0);
		bus(1'b1, `A_CTRL, 32'h42);
		run(1'b1, 1'b0, 32'h0, 32'h0);
		// Matching frame with the power event enable off; IPv6 frame with only IPv4 enabled; bad IPv6 address
		bus(1'b1, `A_CTRL, 32'h01);
		run(1'b1, 1'b0, 32'h0, 32'h0);
		build(1'b1, 1'b0, 1'b1, 32'h0);
		bus(1'b1, `A_CTRL, 32'h41);
		run(1'b1, 1'b0, 32'h0, 32'h0);
		bus(1'b1, `A_CTRL, 32'h42);
		f[45] = 8'h00;
		run(1'b1, 1'b0, 32'h0, 32'h0);
		// Each flexible filter: tag bytes at 12..13, byte 19 last, byte 25 past length
		for (int g = 0; g < 4; g++) begin
			bus(1'b1, 12'h040 + 4 * g, 32'h14);
			bus(1'b1, 12'h080 + 16 * g, 32'h02083001);
			bus(1'b1, 12'h400 + 128 * g, 32'h2);
			bus(1'b1, 12'h40c + 128 * g, 32'h81);
			bus(1'b1, 12'h418 + 128 * g, 32'hff00);
			bus(1'b1, `A_CTRL, 32'h40 | (32'h4 << g));
			build(1'b1, 1'b0, 1'b0, 32'h0);
			run(1'b1, 1'b0, 32'h1, 32'h40 | (32'h4 << g));
			clr();
			f[19] = 8'h01;
			run(1'b1, 1'b0, 32'h0, 32'h0);
			build(1'b0, 1'b0, 1'b0, 32'h0);
			run(1'b1, 1'b0, 32'h0, 32'h0);
		end
		// Two filters hit one frame: one pulse, both bits
		bus(1'b1, `A_CTRL, 32'h45);
		build(1'b1, 1'b0, 1'b0, 32'h0a000002);
		run(1'b1, 1'b0, 32'h1, 32'h45);
		// Frozen: bus stalls and a matching frame leaves no trace
		clr();
		ce_q <= 1'b0;
		u_frame_source.send(72, 1'b1, 1'b0);
		check1(hreadyout_o, 1'b0);
		ce_q <= 1'b1;
		rdc(`A_STAT, 32'h0);
		finish_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#3000000;
		miscompares++;
		finish_test();
	end
endmodule
